//--- brgs_pkg.sv
// Constants and types for the bypass router contact select block
// What this block does
// [RULE1] Contact select asserted only when driven low
// [RULE2] Floating contact reads inactive, never switches routing
// [RULE3] Manual: contact one pulse puts input one on program
// [RULE4] Manual: contact two pulse puts input two on program
// [RULE5] Tally one high while input one on program
// [RULE6] Tally two high while input two on program
// [RULE7] Automatic: exactly one contact forces route, overrides quality
// [RULE8] Automatic: both high or low keeps quality switching
// [RULE9] Outputs keep the input video standard, no conversion
// [RULE10] Program outputs two and three follow output one
// [RULE11] Detect standard or high definition serial rate
// [RULE12] Detect colour black or tri-level reference automatically
// [RULE13] Input one primary, input two backup or preview
// [RULE14] Synchronise, debounce; completed low pulse is one request
package brgs_pkg;
	// Clock period in nanoseconds
	localparam int unsigned CLK_PERIOD_NS = 8;
	// Least stable time of a contact before it is believed, in microseconds
	localparam int unsigned DEB_TIME_US = 10000;
	// Debounce time as clock cycles, rounded up
	localparam int unsigned DEB_CYCLES = (DEB_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Measurement window for rate and reference detection, in microseconds
	localparam int unsigned WIN_TIME_US = 100;
	// Window as clock cycles, rounded down
	localparam int unsigned WIN_CYCLES = (WIN_TIME_US * 1000) / CLK_PERIOD_NS;
	// Least transition count in one window that marks a high definition rate
	localparam int unsigned HD_TRANS_MIN = 6000;
	// Number of video inputs and program outputs
	localparam int unsigned NUM_INPUTS = 2;
	localparam int unsigned NUM_PGM = 3;
	// Idle level of a contact line (pulled up)
	localparam logic CONTACT_IDLE = 1'b1;
	// Route state: which input is on program
	typedef enum logic [1:0]
	{
		ROUTE_ONE = 2'b01,
		ROUTE_TWO = 2'b10
	} brgs_route_type;
	// Route taken out of reset
	localparam brgs_route_type ROUTE_RESET = ROUTE_ONE;
endpackage : brgs_pkg

//--- brgs_contact_if.sv
// Carrier between a raw contact line and its filter
`timescale 1ns/1ns
interface brgs_contact_if;
	logic raw_n; // Raw contact level, low is asserted
	logic held_low; // Debounced level, high while contact is closed
	logic release_pulse; // One cycle at the end of a completed closure
	// Filter side
	modport filt
	(
		input raw_n,
		output held_low,
		output release_pulse
	);
	// User side
	modport user
	(
		output raw_n,
		input held_low,
		input release_pulse
	);
endinterface : brgs_contact_if

//--- brgs_debounce.sv
// Synchroniser and debounce filter for one contact line
`timescale 1ns/1ns
module brgs_debounce
#(
	parameter int unsigned DEB_CYCLES = brgs_pkg::DEB_CYCLES
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Contact carrier
	brgs_contact_if.filt contact
);
	import brgs_pkg::*;
	localparam int unsigned CW = $clog2(DEB_CYCLES + 1);
	logic sync1_r; // First synchroniser stage
	logic sync2_r; // Second synchroniser stage
	logic stable_r; // Debounced contact level
	logic stable_nxt;
	logic [CW-1:0] cnt_r; // Cycles the level has differed
	logic [CW-1:0] cnt_nxt;
	logic rel_r; // Release pulse
	logic rel_nxt;
	// Next filter state
	always_comb
	begin
		stable_nxt = stable_r;
		cnt_nxt = cnt_r;
		rel_nxt = 1'b0;
		if (sync2_r == stable_r)
		begin
			// Bounce back, restart the wait
			cnt_nxt = '0;
		end
		else if (cnt_r == CW'(DEB_CYCLES - 1))
		begin
			// Level held long enough, take it
			stable_nxt = sync2_r;
			cnt_nxt = '0;
			rel_nxt = sync2_r; // RULE14
		end
		else
		begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end
	// Registers; idle level at reset so a floating line never acts
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync1_r <= CONTACT_IDLE; // RULE2
			sync2_r <= CONTACT_IDLE;
			stable_r <= CONTACT_IDLE;
			cnt_r <= '0;
			rel_r <= 1'b0;
		end
		else
		begin
			sync1_r <= contact.raw_n; // RULE14
			sync2_r <= sync1_r;
			stable_r <= stable_nxt;
			cnt_r <= cnt_nxt;
			rel_r <= rel_nxt;
		end
	end
	// Low level means closed
	assign contact.held_low = ~stable_r; // RULE1
	assign contact.release_pulse = rel_r;
endmodule : brgs_debounce

//--- brgs_router_ctrl.sv
// Route selection, tally and format detection for the bypass router
`timescale 1ns/1ns
module brgs_router_ctrl
#(
	parameter int unsigned DEB_CYCLES = brgs_pkg::DEB_CYCLES,
	parameter int unsigned WIN_CYCLES = brgs_pkg::WIN_CYCLES,
	parameter int unsigned HD_TRANS_MIN = brgs_pkg::HD_TRANS_MIN
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Contact inputs, low is asserted
	input wire logic select_input_one_contact_n_i,
	input wire logic select_input_two_contact_n_i,
	// Mode: high selects automatic switching
	input wire logic switch_mode_setting_i,
	// Per-input quality and transition samples
	input wire logic [brgs_pkg::NUM_INPUTS-1:0] input_valid_i,
	input wire logic [brgs_pkg::NUM_INPUTS-1:0] vid_trans_i,
	// Reference sync excursions above and below blanking
	input wire logic ref_pos_i,
	input wire logic ref_neg_i,
	// Crosspoint selects, high picks input two
	output logic [brgs_pkg::NUM_PGM-1:0] pgm_sel_o,
	output logic prev_sel_o,
	// Standard of each input and of each bus
	output logic [brgs_pkg::NUM_INPUTS-1:0] input_hd_o,
	output logic pgm_hd_o,
	output logic prev_hd_o,
	// Reference detection
	output logic ref_present_o,
	output logic ref_trilevel_o,
	// Tallies
	output logic tally_input_one_o,
	output logic tally_input_two_o
);
	import brgs_pkg::*;
	localparam int unsigned WW = $clog2(WIN_CYCLES + 1);

	// Contact filters, one per contact line
	logic [1:0] raw_n; // Raw contact levels
	logic [1:0] held_low; // Debounced closed levels
	logic [1:0] rel; // Completed closure pulses
	assign raw_n = {select_input_two_contact_n_i, select_input_one_contact_n_i};
	generate
		for (genvar c = 0; c < 2; c++)
		begin : g_contact
			brgs_contact_if cif ();
			assign cif.raw_n = raw_n[c];
			assign held_low[c] = cif.held_low;
			assign rel[c] = cif.release_pulse;
			brgs_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb
			(
				.clk_i(clk_i),
				.rst_i(rst_i),
				.contact(cif.filt)
			);
		end
	endgenerate

	// Route state
	brgs_route_type route_r; // Input now on program
	brgs_route_type route_nxt;
	logic auto_force; // Exactly one contact held, in either mode; only automatic mode acts on it
	assign auto_force = held_low[0] ^ held_low[1]; // RULE7 RULE8

	// Next route
	always_comb
	begin
		route_nxt = route_r;
		if (!switch_mode_setting_i)
		begin
			// Manual: act on a completed pulse, ignore a tie
			if (rel[0] && !rel[1])
			begin
				route_nxt = ROUTE_ONE; // RULE3
			end
			else if (rel[1] && !rel[0])
			begin
				route_nxt = ROUTE_TWO; // RULE4
			end
		end
		else if (auto_force)
		begin
			// Forced route beats signal quality
			route_nxt = held_low[0] ? ROUTE_ONE : ROUTE_TWO; // RULE7
		end
		else
		begin
			// Quality switching, primary preferred
			if (input_valid_i[0])
			begin
				route_nxt = ROUTE_ONE; // RULE8 RULE13
			end
			else if (input_valid_i[1])
			begin
				route_nxt = ROUTE_TWO; // RULE8
			end
		end
	end

	// Route register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			route_r <= ROUTE_RESET; // RULE13
		end
		else
		begin
			route_r <= route_nxt;
		end
	end

	// Window timer and per-window measurements
	logic [WW-1:0] win_r; // Window cycle count
	logic [WW-1:0] win_nxt;
	logic win_end; // Last cycle of a window
	logic pos_seen_r; // Positive excursion seen this window
	logic pos_seen_nxt;
	logic neg_seen_r; // Negative excursion seen this window
	logic neg_seen_nxt;
	logic ref_present_r;
	logic ref_present_nxt;
	logic ref_tri_r;
	logic ref_tri_nxt;
	logic [NUM_INPUTS-1:0] hd_r; // Detected rate per input
	logic [NUM_INPUTS-1:0] hd_nxt;
	wire [NUM_INPUTS-1:0] hd_hit; // Window count at or above the threshold
	assign win_end = (win_r == WW'(WIN_CYCLES - 1));

	// Next window and reference state
	always_comb
	begin
		win_nxt = win_end ? '0 : win_r + 1'b1;
		pos_seen_nxt = win_end ? 1'b0 : (pos_seen_r | ref_pos_i);
		neg_seen_nxt = win_end ? 1'b0 : (neg_seen_r | ref_neg_i);
		ref_present_nxt = ref_present_r;
		ref_tri_nxt = ref_tri_r;
		// Rate decision taken once per window
		hd_nxt = win_end ? hd_hit : hd_r; // RULE11
		if (win_end)
		begin
			// Tri-level has a positive pulse, black burst does not
			ref_present_nxt = pos_seen_r | neg_seen_r | ref_pos_i | ref_neg_i; // RULE12
			ref_tri_nxt = pos_seen_r | ref_pos_i; // RULE12
		end
	end

	// Per-input transition counters
	generate
		for (genvar i = 0; i < NUM_INPUTS; i++)
		begin : g_rate
			logic [WW-1:0] trans_r; // Transitions this window
			logic [WW-1:0] trans_nxt;
			// Next count
			always_comb
			begin
				trans_nxt = win_end ? '0 : trans_r + WW'(vid_trans_i[i]);
			end
			// Dense transitions mean the faster rate
			assign hd_hit[i] = (trans_r >= WW'(HD_TRANS_MIN)); // RULE11
			// Count register
			always_ff @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					trans_r <= '0;
				end
				else
				begin
					trans_r <= trans_nxt;
				end
			end
		end
	endgenerate

	// Window and detection registers
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			win_r <= '0;
			pos_seen_r <= 1'b0;
			neg_seen_r <= 1'b0;
			ref_present_r <= 1'b0;
			ref_tri_r <= 1'b0;
			hd_r <= '0;
		end
		else
		begin
			win_r <= win_nxt;
			pos_seen_r <= pos_seen_nxt;
			neg_seen_r <= neg_seen_nxt;
			ref_present_r <= ref_present_nxt;
			ref_tri_r <= ref_tri_nxt;
			hd_r <= hd_nxt;
		end
	end

	// Output registers
	logic [NUM_PGM-1:0] pgm_sel_r;
	logic [NUM_PGM-1:0] pgm_sel_nxt;
	logic prev_sel_r;
	logic prev_sel_nxt;
	logic pgm_hd_r;
	logic pgm_hd_nxt;
	logic prev_hd_r;
	logic prev_hd_nxt;
	logic tally_one_r;
	logic tally_one_nxt;
	logic tally_two_r;
	logic tally_two_nxt;

	// Next output values from the route
	always_comb
	begin
		// All program outputs share one select
		pgm_sel_nxt = {NUM_PGM{route_nxt == ROUTE_TWO}}; // RULE10
		prev_sel_nxt = (route_nxt == ROUTE_ONE); // RULE3 RULE4
		// Buses carry the standard of their source
		pgm_hd_nxt = (route_nxt == ROUTE_TWO) ? hd_nxt[1] : hd_nxt[0]; // RULE9
		prev_hd_nxt = (route_nxt == ROUTE_TWO) ? hd_nxt[0] : hd_nxt[1]; // RULE9
		tally_one_nxt = (route_nxt == ROUTE_ONE); // RULE5
		tally_two_nxt = (route_nxt == ROUTE_TWO); // RULE6
	end

	// Register outputs, reset to primary on program
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pgm_sel_r <= '0;
			prev_sel_r <= 1'b1;
			pgm_hd_r <= 1'b0;
			prev_hd_r <= 1'b0;
			tally_one_r <= 1'b1;
			tally_two_r <= 1'b0;
		end
		else
		begin
			pgm_sel_r <= pgm_sel_nxt;
			prev_sel_r <= prev_sel_nxt;
			pgm_hd_r <= pgm_hd_nxt;
			prev_hd_r <= prev_hd_nxt;
			tally_one_r <= tally_one_nxt;
			tally_two_r <= tally_two_nxt;
		end
	end

	// Drive ports
	assign pgm_sel_o = pgm_sel_r;
	assign prev_sel_o = prev_sel_r;
	assign input_hd_o = hd_r;
	assign pgm_hd_o = pgm_hd_r;
	assign prev_hd_o = prev_hd_r;
	assign ref_present_o = ref_present_r;
	assign ref_trilevel_o = ref_tri_r;
	assign tally_input_one_o = tally_one_r;
	assign tally_input_two_o = tally_two_r;
endmodule : brgs_router_ctrl

//--- brgs_router_ctrl_properties.sv
// Checker of route, tally and format outputs of the router control
`timescale 1ns/1ns
module brgs_router_ctrl_properties
#(
	parameter int unsigned DEB_CYCLES = 4,
	parameter int unsigned WIN_CYCLES = 16,
	parameter int unsigned HD_TRANS_MIN = 8
)
(
	// Clock, reset and contacts
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic select_input_one_contact_n_i,
	input wire logic select_input_two_contact_n_i,
	input wire logic switch_mode_setting_i,
	// Observed outputs
	input wire logic [brgs_pkg::NUM_INPUTS-1:0] input_hd_o,
	input wire logic [brgs_pkg::NUM_PGM-1:0] pgm_sel_o,
	input wire logic prev_sel_o,
	input wire logic pgm_hd_o,
	input wire logic prev_hd_o,
	input wire logic ref_present_o,
	input wire logic ref_trilevel_o,
	input wire logic tally_input_one_o,
	input wire logic tally_input_two_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Run lengths: manual idle, forced one, forced two
	int idle_r, idle_nxt, f1_r, f1_nxt, f2_r, f2_nxt;
	logic c1, c2;
	assign c1 = select_input_one_contact_n_i;
	assign c2 = select_input_two_contact_n_i;
	// Next run lengths
	always_comb
	begin
		idle_nxt = (!switch_mode_setting_i && c1 && c2) ? idle_r + 1 : 0;
		f1_nxt = (switch_mode_setting_i && !c1 && c2) ? f1_r + 1 : 0;
		f2_nxt = (switch_mode_setting_i && c1 && !c2) ? f2_r + 1 : 0;
	end
	// Run length registers
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			idle_r <= 0;
			f1_r <= 0;
			f2_r <= 0;
		end
		else
		begin
			idle_r <= idle_nxt;
			f1_r <= f1_nxt;
			f2_r <= f2_nxt;
		end
	end
	tally_exclusive_a: assert property (tally_input_one_o != tally_input_two_o)
		else $error("tallies not exclusive");
	tally_route_a: assert property (tally_input_two_o == pgm_sel_o[0])
		else $error("tally two differs from route");
	pgm_copies_a: assert property (pgm_sel_o[2:1] == {2{pgm_sel_o[0]}})
		else $error("program selects differ");
	prev_opposite_a: assert property (prev_sel_o != pgm_sel_o[0])
		else $error("preview equals program");
	pgm_standard_a: assert property (pgm_hd_o == input_hd_o[pgm_sel_o[0]])
		else $error("program standard wrong");
	prev_standard_a: assert property (prev_hd_o == input_hd_o[prev_sel_o])
		else $error("preview standard wrong");
	ref_kind_a: assert property (ref_trilevel_o |-> ref_present_o)
		else $error("tri-level without reference");
	manual_idle_a: assert property (idle_r > DEB_CYCLES + 8 |-> $stable(pgm_sel_o))
		else $error("route moved with open contacts");
	force_one_a: assert property (f1_r > DEB_CYCLES + 6 |-> pgm_sel_o == 3'h0)
		else $error("forced input one not on program");
	force_two_a: assert property (f2_r > DEB_CYCLES + 6 |-> pgm_sel_o == 3'h7)
		else $error("forced input two not on program");
endmodule : brgs_router_ctrl_properties
bind brgs_router_ctrl brgs_router_ctrl_properties #(.DEB_CYCLES(DEB_CYCLES),
	.WIN_CYCLES(WIN_CYCLES), .HD_TRANS_MIN(HD_TRANS_MIN)) i_props (.clk_i(clk_i),
	.rst_i(rst_i), .select_input_one_contact_n_i(select_input_one_contact_n_i),
	.select_input_two_contact_n_i(select_input_two_contact_n_i),
	.switch_mode_setting_i(switch_mode_setting_i), .input_hd_o(input_hd_o),
	.pgm_sel_o(pgm_sel_o), .prev_sel_o(prev_sel_o), .pgm_hd_o(pgm_hd_o),
	.prev_hd_o(prev_hd_o), .ref_present_o(ref_present_o), .ref_trilevel_o(ref_trilevel_o),
	.tally_input_one_o(tally_input_one_o), .tally_input_two_o(tally_input_two_o));

//--- brgs_contact_model.sv
// Model of the two contact closures with their pull-ups
`timescale 1ns/1ns
module brgs_contact_model
(
	// Closure requests
	input wire logic press_one_i,
	input wire logic press_two_i,
	// Contact lines
	output logic select_input_one_contact_n_o,
	output logic select_input_two_contact_n_o
);
	// Closed pulls to ground, open floats up to the pull-up
	assign select_input_one_contact_n_o = press_one_i ? 1'b0 : 1'b1;
	assign select_input_two_contact_n_o = press_two_i ? 1'b0 : 1'b1;
endmodule : brgs_contact_model

//--- brgs_router_ctrl_test.sv
// Self-checking bench of the bypass router control
`timescale 1ns/1ns
module brgs_router_ctrl_test;
	import brgs_pkg::*;
	localparam int D = 4;
	logic clk_i = 0, rst_i = 1, mode = 0, p1 = 0, p2 = 0, rpos = 0, rneg = 0;
	logic [1:0] valid = 0, trans = 0, ihd;
	logic c1_n, c2_n, pv, phd, vhd, rp, rt, t1, t2;
	logic [2:0] pgm;
	logic [3:0] steps [7] = '{4'h2, 4'h3, 4'h0, 4'h5, 4'hA, 4'hE, 4'h1};
	bit e2 = 0;
	int n_fail = 0, compares = 0, cyc = 0;
	int unsigned seed = 65952, r;
	brgs_contact_model i_brgs_contact_model (.press_one_i(p1), .press_two_i(p2),
		.select_input_one_contact_n_o(c1_n), .select_input_two_contact_n_o(c2_n));
	brgs_router_ctrl #(.DEB_CYCLES(D), .WIN_CYCLES(16), .HD_TRANS_MIN(8)) i_brgs_router_ctrl (
		.clk_i(clk_i), .rst_i(rst_i), .select_input_one_contact_n_i(c1_n),
		.select_input_two_contact_n_i(c2_n), .switch_mode_setting_i(mode),
		.input_valid_i(valid), .vid_trans_i(trans), .ref_pos_i(rpos), .ref_neg_i(rneg),
		.pgm_sel_o(pgm), .prev_sel_o(pv), .input_hd_o(ihd), .pgm_hd_o(phd), .prev_hd_o(vhd),
		.ref_present_o(rp), .ref_trilevel_o(rt), .tally_input_one_o(t1),
		.tally_input_two_o(t2));
	always #4 clk_i = ~clk_i;
	// Cut a hang short
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail++;
			test_done();
		end
	end
	function automatic int unsigned xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xorshift
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	// Route outputs against the model
	task check_route();
		chk("pgm_sel", 32'({3{e2}}), 32'(pgm));
		chk("prev_sel", 32'(!e2), 32'(pv));
		chk("tally_one", 32'(!e2), 32'(t1));
		chk("tally_two", 32'(e2), 32'(t2));
	endtask : check_route
	// Manual closure of len cycles, then release and settle
	task press(input bit one, input bit two, input int len);
		@(posedge clk_i);
		p1 <= one;
		p2 <= two;
		repeat (len) @(posedge clk_i);
		p1 <= 0;
		p2 <= 0;
		repeat (D + 8) @(posedge clk_i);
		if (len > D && one != two)
			e2 = two;
		check_route();
	endtask : press
	task test_done();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		check_route();
		chk("ref_present", 32'(0), 32'(rp));
		$display("reset test done");
		press(0, 1, 8);
		press(1, 0, 2);
		press(1, 1, 8);
		press(1, 0, 8);
		repeat (8)
		begin
			r = xorshift();
			valid <= r[4:3];
			press(r[0], r[1], r[2] ? 8 : 2);
		end
		$display("manual test done");
		mode <= 1;
		foreach (steps[i])
		begin
			@(posedge clk_i);
			{p1, p2, valid} <= steps[i];
			repeat (D + 10) @(posedge clk_i);
			if (steps[i][3] != steps[i][2])
				e2 = steps[i][2];
			else if (steps[i][0])
				e2 = 0;
			else if (steps[i][1])
				e2 = 1;
			check_route();
		end
		$display("automatic test done");
		trans <= 2'h1;
		rpos <= 1;
		repeat (48) @(posedge clk_i);
		chk("input_hd", 32'(2'h1), 32'(ihd));
		chk("pgm_hd", 32'(1), 32'(phd));
		chk("ref_trilevel", 32'(1), 32'(rt));
		trans <= 2'h2;
		rpos <= 0;
		rneg <= 1;
		repeat (48) @(posedge clk_i);
		chk("input_hd", 32'(2'h2), 32'(ihd));
		chk("prev_hd", 32'(1), 32'(vhd));
		chk("ref_present", 32'(1), 32'(rp));
		chk("ref_trilevel", 32'(0), 32'(rt));
		$display("detection test done");
		test_done();
	end
endmodule : brgs_router_ctrl_test
